// File: core/pmx_ahb_slave.sv
`timescale 1ns/10ps
// =============================================================================
// AHB-Lite slave front end: one wait state per transfer, always OKAY.
module pmx_ahb_slave
    import pmx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [15:0] rd_data,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic rd_en,
    output logic [5:0] reg_offset,
    output logic [15:0] wr_data
);

    pmx_slave_type st_ff;
    pmx_slave_type nxt_st;

    // The wait state lets a write from the previous transfer settle before
    // the next read samples the register file, at the cost of one cycle.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.hresp = 1'b0;
        if (st_ff.phase == ph_data)
        begin
            nxt_st.phase = ph_idle;
            nxt_st.hreadyout = 1'b1;
            if (!st_ff.write)
                nxt_st.hrdata = st_ff.hit ? {16'h0000, rd_data} : 32'h0000_0000;
        end
        else if (hsel && htrans[1] && hready)
        begin
            nxt_st.phase = ph_data;
            nxt_st.write = hwrite;
            nxt_st.hit = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0);
            nxt_st.offset = haddr[5:0];
            nxt_st.hreadyout = 1'b0;
        end
    end

    // Slave state register; ready is high out of reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
            st_ff.hreadyout <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // Strobes toward the register file, active in the wait cycle.
    assign wr_en = (st_ff.phase == ph_data) && st_ff.write && st_ff.hit;
    // Reads that miss the map answer zero, so they do not count as register reads.
    assign rd_en = (st_ff.phase == ph_data) && !st_ff.write && st_ff.hit;
    assign reg_offset = st_ff.offset;
    assign wr_data = hwdata[15:0];
    assign hreadyout = st_ff.hreadyout;
    assign hresp = st_ff.hresp;
    assign hrdata = st_ff.hrdata;

endmodule // pmx_ahb_slave

// File: core/pmx_pin_mux.sv
`timescale 1ns/10ps
// Operation
// - Group one pins 4-7 are full GPIO
// - Group one pins 0-3 GPIO bits read zero
// - Interrupt and filter registers read zero, ignore writes
// - Group two pins 0-1 GPIO, out bits 9:8
// - Group two pins 2-7 GPIO bits read zero
// - Mode bit per pin selects GPIO or peripheral
// - Two-bit function field; function 0 routes sync serial
// - Function 1 routes two-wire and hysteresis inputs
// - Function 3 drives display segments 3 to 13
// - Group two fixed fields; pins 0-1 async serial
module pmx_pin_mux
    import pmx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] pad_in,
    output pmx_pad_type pad,
    input wire pmx_drive_type drive,
    output pmx_sense_type sense
);

    // =========================================================================
    // Bus front end and pad input synchroniser.
    pmx_state_type st_ff;
    pmx_state_type nxt_st;
    logic wr_en;
    logic rd_en;
    logic [5:0] reg_offset;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic [15:0] pin_s;
    logic [15:0] sel16;
    logic [31:0] fnc32;

    pmx_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .rd_data(rd_data),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .reg_offset(reg_offset),
        .wr_data(wr_data)
    );

    pmx_sync #(.WIDTH(16)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pad_in),
        .sync_out(pin_s)
    );

    // =========================================================================
    // Mode and function selection seen across both groups.
    function automatic logic routed(input logic [15:0] sel, input logic [31:0] fnc,
                                    input int p, input logic [1:0] f);
        routed = sel[p] && (fnc[2*p +: 2] == f);
    endfunction

    // Group two fields for pins 2-7 are fixed at function 3.
    assign sel16 = {st_ff.g2_sel, st_ff.g1_sel};
    assign fnc32 = {G2_FUNC_FIXED, st_ff.g2_fnc, st_ff.g1_fnc};

    // =========================================================================
    // Read mux; reserved fields and absent registers answer zero.
    always_comb
    begin
        rd_data = 16'h0000;
        case (reg_offset)
            OFF_G1_DATA:
            begin
                rd_data[G1_HI_LSB +: 4] = st_ff.g1_out;
                rd_data[G1_LO_LSB +: 4] = pin_s[7:4] & st_ff.g1_ie;
            end
            OFF_G1_ENABLES:
            begin
                rd_data[G1_HI_LSB +: 4] = st_ff.g1_ie;
                rd_data[G1_LO_LSB +: 4] = st_ff.g1_oe;
            end
            OFF_G1_PULL:
            begin
                rd_data[G1_HI_LSB +: 4] = st_ff.g1_pdpu;
                rd_data[G1_LO_LSB +: 4] = st_ff.g1_ren;
            end
            OFF_G1_MODE: rd_data[7:0] = st_ff.g1_sel;
            OFF_G1_FUNC: rd_data = st_ff.g1_fnc;
            OFF_G2_DATA:
            begin
                rd_data[G2_HI_LSB +: 2] = st_ff.g2_out;
                rd_data[G2_LO_LSB +: 2] = pin_s[9:8] & st_ff.g2_ie;
            end
            OFF_G2_ENABLES:
            begin
                rd_data[G2_HI_LSB +: 2] = st_ff.g2_ie;
                rd_data[G2_LO_LSB +: 2] = st_ff.g2_oe;
            end
            OFF_G2_PULL:
            begin
                rd_data[G2_HI_LSB +: 2] = st_ff.g2_pdpu;
                rd_data[G2_LO_LSB +: 2] = st_ff.g2_ren;
            end
            OFF_G2_MODE: rd_data[7:0] = st_ff.g2_sel;
            OFF_G2_FUNC: rd_data = fnc32[31:16];
            default: rd_data = 16'h0000;
        endcase
    end

    // =========================================================================
    // Next state: register writes, then the pad and peripheral routing.
    always_comb
    begin
        logic [3:0] c_out [0:15];
        logic [3:0] c_oe [0:15];
        logic [3:0] c_in [0:15];
        logic [15:0] g_out;
        logic [15:0] g_oe;
        logic [15:0] g_ie;
        logic [15:0] g_ren;
        logic [15:0] g_pdpu;
        logic [1:0] f;
        for (int p = 0; p < 16; p++)
        begin
            c_out[p] = 4'h0;
            c_oe[p] = 4'h0;
            c_in[p] = 4'h0;
        end
        g_out = 16'h0000;
        g_oe = 16'h0000;
        g_ie = 16'h0000;
        g_ren = 16'h0000;
        g_pdpu = 16'h0000;
        f = FN_ZERO;
        nxt_st = st_ff;

        // Only implemented bits take writes; absent registers fall through.
        if (wr_en)
        begin
            case (reg_offset)
                OFF_G1_DATA: nxt_st.g1_out = wr_data[G1_HI_LSB +: 4];
                OFF_G1_ENABLES:
                begin
                    nxt_st.g1_ie = wr_data[G1_HI_LSB +: 4];
                    nxt_st.g1_oe = wr_data[G1_LO_LSB +: 4];
                end
                OFF_G1_PULL:
                begin
                    nxt_st.g1_pdpu = wr_data[G1_HI_LSB +: 4];
                    nxt_st.g1_ren = wr_data[G1_LO_LSB +: 4];
                end
                OFF_G1_MODE: nxt_st.g1_sel = wr_data[7:0];
                OFF_G1_FUNC: nxt_st.g1_fnc = wr_data;
                OFF_G2_DATA: nxt_st.g2_out = wr_data[G2_HI_LSB +: 2];
                OFF_G2_ENABLES:
                begin
                    nxt_st.g2_ie = wr_data[G2_HI_LSB +: 2];
                    nxt_st.g2_oe = wr_data[G2_LO_LSB +: 2];
                end
                OFF_G2_PULL:
                begin
                    nxt_st.g2_pdpu = wr_data[G2_HI_LSB +: 2];
                    nxt_st.g2_ren = wr_data[G2_LO_LSB +: 2];
                end
                OFF_G2_MODE: nxt_st.g2_sel = wr_data[7:0];
                OFF_G2_FUNC: nxt_st.g2_fnc = wr_data[3:0];
                default: nxt_st.g1_sel = st_ff.g1_sel;
            endcase
        end

        // GPIO controls spread onto pad positions; pins without GPIO stay zero.
        g_out[7:4] = st_ff.g1_out;
        g_oe[7:4] = st_ff.g1_oe;
        g_ie[7:4] = st_ff.g1_ie;
        g_ren[7:4] = st_ff.g1_ren;
        g_pdpu[7:4] = st_ff.g1_pdpu;
        g_out[9:8] = st_ff.g2_out;
        g_oe[9:8] = st_ff.g2_oe;
        g_ie[9:8] = st_ff.g2_ie;
        g_ren[9:8] = st_ff.g2_ren;
        g_pdpu[9:8] = st_ff.g2_pdpu;

        // Function 0: sync serial on group one, async serial on group two.
        c_in[0][0] = 1'b1;
        c_out[1][0] = drive.sync_serial0_data_out;
        c_oe[1][0] = 1'b1;
        c_out[2][0] = drive.sync_serial0_clock;
        c_oe[2][0] = drive.sync_serial0_clock_oe;
        c_in[2][0] = 1'b1;
        for (int p = 3; p < 5; p++)
        begin
            c_out[p][0] = drive.sync_serial0_slave_select_n;
            c_oe[p][0] = drive.sync_serial0_slave_select_n_oe;
            c_in[p][0] = 1'b1;
        end
        c_in[8][0] = 1'b1;
        c_out[9][0] = drive.async_serial0_transmit;
        c_oe[9][0] = 1'b1;

        // Function 1: two-wire lines are open drain, driving only low.
        c_oe[0][1] = drive.two_wire0_clock_oe;
        c_in[0][1] = 1'b1;
        c_oe[1][1] = drive.two_wire0_data_oe;
        c_in[1][1] = 1'b1;
        c_in[2][1] = 1'b1;
        c_in[3][1] = 1'b1;
        c_out[9][1] = drive.sensor_enable_output;
        c_oe[9][1] = 1'b1;

        // Function 2: comparator inputs.
        c_in[5][2] = 1'b1;
        c_in[6][2] = 1'b1;
        c_in[7][2] = 1'b1;
        c_in[8][2] = 1'b1;

        // Function 3: display segments on group one 0-3 and group two 1-7.
        for (int p = 0; p < 4; p++)
        begin
            c_out[p][3] = drive.display_segment_output[p + 3];
            c_oe[p][3] = 1'b1;
        end
        for (int p = 9; p < 16; p++)
        begin
            c_out[p][3] = drive.display_segment_output[p - 2];
            c_oe[p][3] = 1'b1;
        end

        // Pad mux; unlisted combinations keep all-zero candidates.
        for (int p = 0; p < 16; p++)
        begin
            f = fnc32[2*p +: 2];
            if (sel16[p])
            begin
                nxt_st.pad.out[p] = c_out[p][f];
                nxt_st.pad.oe[p] = c_oe[p][f];
                nxt_st.pad.in_en[p] = c_in[p][f];
                nxt_st.pad.pull_en[p] = 1'b0;
                nxt_st.pad.pull_up[p] = 1'b0;
            end
            else
            begin
                nxt_st.pad.out[p] = g_out[p];
                nxt_st.pad.oe[p] = g_oe[p];
                nxt_st.pad.in_en[p] = g_ie[p];
                nxt_st.pad.pull_en[p] = g_ren[p];
                nxt_st.pad.pull_up[p] = g_pdpu[p];
            end
        end

        // Peripheral inputs take the pad level only while routed, else idle.
        nxt_st.sense.sync_serial0_data_in = routed(sel16, fnc32, 0, FN_ZERO) & pin_s[0];
        nxt_st.sense.sync_serial0_clock = routed(sel16, fnc32, 2, FN_ZERO) & pin_s[2];
        // Pin 3 wins when both slave-select pins are routed at once.
        if (routed(sel16, fnc32, 3, FN_ZERO))
            nxt_st.sense.sync_serial0_slave_select_n = pin_s[3];
        else if (routed(sel16, fnc32, 4, FN_ZERO))
            nxt_st.sense.sync_serial0_slave_select_n = pin_s[4];
        else
            nxt_st.sense.sync_serial0_slave_select_n = 1'b1;
        nxt_st.sense.two_wire0_clock = routed(sel16, fnc32, 0, FN_ONE) ? pin_s[0] : 1'b1;
        nxt_st.sense.two_wire0_data = routed(sel16, fnc32, 1, FN_ONE) ? pin_s[1] : 1'b1;
        nxt_st.sense.hysteresis_input_one = routed(sel16, fnc32, 2, FN_ONE) & pin_s[2];
        nxt_st.sense.hysteresis_input_zero = routed(sel16, fnc32, 3, FN_ONE) & pin_s[3];
        nxt_st.sense.comparator_pos_in_one = routed(sel16, fnc32, 5, FN_TWO) & pin_s[5];
        nxt_st.sense.comparator_neg_in_one = routed(sel16, fnc32, 6, FN_TWO) & pin_s[6];
        nxt_st.sense.comparator_neg_in_zero = routed(sel16, fnc32, 7, FN_TWO) & pin_s[7];
        nxt_st.sense.comparator_pos_in_zero = routed(sel16, fnc32, 8, FN_TWO) & pin_s[8];
        nxt_st.sense.async_serial0_receive = routed(sel16, fnc32, 8, FN_ZERO) ? pin_s[8] : 1'b1;
    end

    // =========================================================================
    // State register; idle-high peripheral inputs come out of reset high.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
            st_ff.sense.sync_serial0_slave_select_n <= 1'b1;
            st_ff.sense.two_wire0_clock <= 1'b1;
            st_ff.sense.two_wire0_data <= 1'b1;
            st_ff.sense.async_serial0_receive <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign pad = st_ff.pad;
    assign sense = st_ff.sense;

    // =========================================================================
    // Assertions and covers.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    gpio_g1_out_a: assert property (!st_ff.g1_sel[4] |=>
        pad.out[4] == $past(st_ff.g1_out[0]) && pad.oe[4] == $past(st_ff.g1_oe[0]))
        else $error("group one pin 4 does not follow its GPIO bits");
    no_gpio_low_a: assert property (st_ff.g1_sel[3:0] == 4'h0 |=>
        pad.oe[3:0] == 4'h0 && pad.pull_en[3:0] == 4'h0)
        else $error("group one pins 0-3 act as GPIO");
    absent_regs_a: assert property (rd_en &&
        (reg_offset == OFF_G1_IRQ_FLAGS || reg_offset == OFF_G2_FILTER) |=> hrdata == 32'h0)
        else $error("absent register reads nonzero");
    g2_out_pos_a: assert property (rd_en && reg_offset == OFF_G2_DATA |=>
        hrdata[9:8] == $past(st_ff.g2_out))
        else $error("group two output bits misplaced");
    g2_rsvd_a: assert property (rd_en && reg_offset == OFF_G2_ENABLES |=>
        hrdata[15:10] == 6'h0 && hrdata[7:2] == 6'h0)
        else $error("group two reserved bits nonzero");
    mode_gpio_a: assert property (!st_ff.g2_sel[1] |=>
        pad.out[9] == $past(st_ff.g2_out[1]))
        else $error("mode bit zero does not give GPIO");
    ssp_route_a: assert property (st_ff.g1_sel[0] && st_ff.g1_fnc[1:0] == FN_ZERO |=>
        sense.sync_serial0_data_in == $past(pin_s[0]))
        else $error("sync serial data input not routed");
    tw_route_a: assert property (st_ff.g1_sel[1] && st_ff.g1_fnc[3:2] == FN_ONE |=>
        sense.two_wire0_data == $past(pin_s[1]))
        else $error("two-wire data not routed");
    seg_route_a: assert property (st_ff.g1_sel[0] && st_ff.g1_fnc[1:0] == FN_THREE |=>
        pad.oe[0] && pad.out[0] == $past(drive.display_segment_output[3]))
        else $error("segment 3 not driven on pin 0");
    fixed_func_a: assert property (rd_en && reg_offset == OFF_G2_FUNC |=>
        hrdata[15:4] == 12'hfff)
        else $error("fixed function fields not 0x3");
    cmp_route_a: assert property (st_ff.g1_sel[7] && st_ff.g1_fnc[15:14] == FN_TWO
        |=> sense.comparator_neg_in_zero == $past(pin_s[7]))
        else $error("comparator input not routed");
    unassigned_a: assert property (st_ff.g1_sel[5] && st_ff.g1_fnc[11:10] == FN_ZERO
        |=> !pad.oe[5] && !pad.in_en[5])
        else $error("unassigned function connects pin 5");

    gpio_drive_c: cover property (!st_ff.g1_sel[4] && st_ff.g1_oe[0] ##1 pad.oe[4]);
    segment_c: cover property (st_ff.g2_sel[7] ##1 pad.oe[15]);
    readback_c: cover property (rd_en && reg_offset == OFF_G1_FUNC);

endmodule // pmx_pin_mux

// File: core/pmx_pkg.sv
// =============================================================================
// Shared constants and carriers of the two-group pin multiplexer.
package pmx_pkg;

    // =========================================================================
    // Register byte offsets; each register is one aligned 32-bit word.
    localparam logic [5:0] OFF_G1_DATA = 6'h00;
    localparam logic [5:0] OFF_G1_ENABLES = 6'h04;
    localparam logic [5:0] OFF_G1_PULL = 6'h08;
    localparam logic [5:0] OFF_G1_IRQ_FLAGS = 6'h0c;
    localparam logic [5:0] OFF_G1_IRQ_CTRL = 6'h10;
    localparam logic [5:0] OFF_G1_FILTER = 6'h14;
    localparam logic [5:0] OFF_G1_MODE = 6'h18;
    localparam logic [5:0] OFF_G1_FUNC = 6'h1c;
    localparam logic [5:0] OFF_G2_DATA = 6'h20;
    localparam logic [5:0] OFF_G2_ENABLES = 6'h24;
    localparam logic [5:0] OFF_G2_PULL = 6'h28;
    localparam logic [5:0] OFF_G2_IRQ_FLAGS = 6'h2c;
    localparam logic [5:0] OFF_G2_IRQ_CTRL = 6'h30;
    localparam logic [5:0] OFF_G2_FILTER = 6'h34;
    localparam logic [5:0] OFF_G2_MODE = 6'h38;
    localparam logic [5:0] OFF_G2_FUNC = 6'h3c;

    // =========================================================================
    // Field positions inside the 16-bit registers.
    localparam int G1_HI_LSB = 12;
    localparam int G1_LO_LSB = 4;
    localparam int G2_HI_LSB = 8;
    localparam int G2_LO_LSB = 0;

    // =========================================================================
    // Fixed read value and function field codes.
    localparam logic [11:0] G2_FUNC_FIXED = 12'hfff;
    localparam logic [1:0] FN_ZERO = 2'h0;
    localparam logic [1:0] FN_ONE = 2'h1;
    localparam logic [1:0] FN_TWO = 2'h2;
    localparam logic [1:0] FN_THREE = 2'h3;

    // =========================================================================
    // Carriers. Pad bits 7:0 are group one, 15:8 are group two.
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
        logic [15:0] pull_en;
        logic [15:0] pull_up;
        logic [15:0] in_en;
    } pmx_pad_type;

    typedef struct packed {
        logic sync_serial0_data_out;
        logic sync_serial0_clock;
        logic sync_serial0_clock_oe;
        logic sync_serial0_slave_select_n;
        logic sync_serial0_slave_select_n_oe;
        logic two_wire0_clock_oe;
        logic two_wire0_data_oe;
        logic async_serial0_transmit;
        logic sensor_enable_output;
        logic [13:3] display_segment_output;
    } pmx_drive_type;

    typedef struct packed {
        logic sync_serial0_data_in;
        logic sync_serial0_clock;
        logic sync_serial0_slave_select_n;
        logic two_wire0_clock;
        logic two_wire0_data;
        logic hysteresis_input_one;
        logic hysteresis_input_zero;
        logic comparator_pos_in_one;
        logic comparator_neg_in_one;
        logic comparator_neg_in_zero;
        logic comparator_pos_in_zero;
        logic async_serial0_receive;
    } pmx_sense_type;

    typedef enum logic {ph_idle, ph_data} pmx_phase_type;

    typedef struct packed {
        pmx_phase_type phase;
        logic write;
        logic hit;
        logic [5:0] offset;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } pmx_slave_type;

    typedef struct packed {
        logic [3:0] g1_out;
        logic [3:0] g1_ie;
        logic [3:0] g1_oe;
        logic [3:0] g1_pdpu;
        logic [3:0] g1_ren;
        logic [7:0] g1_sel;
        logic [15:0] g1_fnc;
        logic [1:0] g2_out;
        logic [1:0] g2_ie;
        logic [1:0] g2_oe;
        logic [1:0] g2_pdpu;
        logic [1:0] g2_ren;
        logic [7:0] g2_sel;
        logic [3:0] g2_fnc;
        pmx_pad_type pad;
        pmx_sense_type sense;
    } pmx_state_type;

endpackage

// File: core/pmx_sync.sv
`timescale 1ns/10ps
// =============================================================================
// Two-stage synchroniser for pad levels arriving from outside the clock domain.
module pmx_sync
    import pmx_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [1:0][WIDTH-1:0] stage_ff;
    logic [1:0][WIDTH-1:0] nxt_stage;

    // Only the second stage is visible; the first may still be metastable.
    always_comb
    begin
        nxt_stage = {stage_ff[0], async_in};
    end

    // Both stages clear to low under reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stage_ff <= '0;
        else
            stage_ff <= nxt_stage;
    end

    assign sync_out = stage_ff[1];

endmodule // pmx_sync

// File: verification/pmx_far_model.sv
`timescale 1ns/10ps
// ====================
// Pads and peripherals as seen from outside the multiplexer.
module pmx_far_model
    import pmx_pkg::*;
(
    input wire pmx_pad_type pad,
    input wire logic [15:0] ext,
    input wire logic [12:0] pat,
    output logic [15:0] pad_in,
    output pmx_drive_type drive
);
    // A pad the block does not drive takes its pull level, else the level forced from outside.
    assign pad_in = (pad.oe & pad.out) | (~pad.oe & pad.pull_en & pad.pull_up)
        | (~pad.oe & ~pad.pull_en & ext);
    // Peripheral outputs stay static within a test, so routing is compared directly.
    assign drive = '{sync_serial0_data_out: pat[11], async_serial0_transmit: pat[12],
        display_segment_output: pat[10:0], default: 1'b0};
endmodule // pmx_far_model

// File: verification/pmx_pin_mux_tb.sv
`timescale 1ns/10ps
// ====================
// Register and routing tests of the two-group pin multiplexer.
module pmx_pin_mux_tb
    import pmx_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [15:0] pad_in;
    logic [15:0] ext = 16'h0;
    logic [12:0] pat = 13'h1aa5;
    pmx_pad_type pad;
    pmx_drive_type drive;
    pmx_sense_type sense;
    int errors = 0;
    int total_checks = 0;
    logic [15:0] ev [16] = '{16'hf0f0, 16'hf0f0, 16'hf0f0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff,
        16'h0303, 16'h0303, 16'h0303, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff};

    // The clock toggles every half period of 25 ns.
    always #25 hclk = ~hclk;

    pmx_pin_mux DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad(pad),
        .drive(drive), .sense(sense));
    pmx_far_model far (.pad(pad), .ext(ext), .pat(pat), .pad_in(pad_in), .drive(drive));

    // ====================
    // Bus and comparison tasks.
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            errors++;
        end
    endtask

    // One single transfer; the wait for ready has no fixed length, the watchdog bounds it.
    task xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 16'h0);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ====================
    // Main sequence.
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset image of the whole map, plus one address past its end.
        for (int i = 0; i < 17; i++)
            rd(8'(i * 4), (i == 15) ? 32'hfff0 : 32'h0);
        $display("test reset done");
        // Ones everywhere; mode high bytes are reserved so only they are written.
        for (int i = 0; i < 16; i++)
            xfer(8'(i * 4), 1'b1, (i % 8 == 6) ? 16'hff00 : 16'hffff);
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 16; i++)
            rd(8'(i * 4), {16'h0, ev[i]});
        chk({pad.out, pad.oe}, 32'h03f003f0);
        chk({pad.pull_en, pad.pull_up}, 32'h03f003f0);
        chk({16'h0, pad.in_en}, 32'h03f0);
        $display("test gpio done");
        // Function 3 on all pins: segments where assigned, silence elsewhere.
        xfer({2'h0, OFF_G1_MODE}, 1'b1, 16'h00ff);
        xfer({2'h0, OFF_G2_MODE}, 1'b1, 16'h00ff);
        repeat (4) @(posedge hclk);
        chk({15'h0, pad.out[15:9], pad.out[3:0], pad.out[8], pad.oe[8], pad.oe[7:4]},
            {15'h0, pat[10:0], 6'h0});
        $display("test display done");
        // Functions 0 to 2 with two opposite outside levels.
        for (int f = 0; f < 3; f++)
        begin
            xfer({2'h0, OFF_G1_FUNC}, 1'b1, {8{f[1:0]}});
            xfer({2'h0, OFF_G2_FUNC}, 1'b1, {8{f[1:0]}});
            for (int k = 0; k < 2; k++)
            begin
                ext <= (k == 1) ? 16'hfe5a : 16'h01a5;
                repeat (6) @(posedge hclk);
                case (f)
                    0: chk({26'h0, sense.sync_serial0_data_in, sense.sync_serial0_slave_select_n,
                        sense.async_serial0_receive, sense.sync_serial0_clock, pad.out[1],
                        pad.out[9]},
                        {26'h0, ext[0], ext[3], ext[8], ext[2], pat[11], pat[12]});
                    1: chk({28'h0, sense.two_wire0_clock, sense.two_wire0_data,
                        sense.hysteresis_input_one, sense.hysteresis_input_zero},
                        {28'h0, ext[0], ext[1], ext[2], ext[3]});
                    default: chk({28'h0, sense.comparator_pos_in_one, sense.comparator_neg_in_one,
                        sense.comparator_neg_in_zero, sense.comparator_pos_in_zero},
                        {28'h0, ext[5], ext[6], ext[7], ext[8]});
                endcase
            end
        end
        $display("test functions done");
        end_sim;
    end

    // Cuts a hang short; the tests need well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge hclk);
        errors++;
        end_sim;
    end
endmodule // pmx_pin_mux_tb
